// *** hdl/ccr_defines.svh ***
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH
`define CCR_ADDR_PORT_IO    16'h0cf8
`define CCR_DATA_WIN_IO     16'h0cfc
`define CCR_ADDR_PORT_RST   32'h00000000
`define CCR_CFG_EN_BIT      31
`define CCR_RSVD_UP_MSB     30
`define CCR_RSVD_UP_LSB     24
`define CCR_BUS_MSB         23
`define CCR_BUS_LSB         16
`define CCR_DEV_MSB         15
`define CCR_DEV_LSB         11
`define CCR_FUNC_MSB        10
`define CCR_FUNC_LSB        8
`define CCR_REG_MSB         7
`define CCR_REG_LSB         2
`define CCR_TYPE1_LOW       2'h1
`define CCR_TYPE0_LOW       2'h0
`define CCR_DEV_HUB_BRIDGE  5'h00
`define CCR_DEV_GFX_BRIDGE  5'h01
`define CCR_DEV_GFX_CTRL    5'h02
`define CCR_DEV_STREAM_PORT 5'h03
`define CCR_DEV_TEST_REGS   5'h06
`define CCR_DEV_TEST_ALT    5'h07
`define CCR_PRIMARY_BUS     8'h00
`define CCR_ROOT_BUS        8'h00
`define CCR_BE_DWORD        4'hf
`endif

// *** hdl/ccr_pkg.sv ***
package ccr_pkg;
  typedef enum logic [3:0] {
    CCR_RT_NONE = 4'h1,
    CCR_RT_INT  = 4'h2,
    CCR_RT_HUB  = 4'h4,
    CCR_RT_GFX  = 4'h8
  } ccr_route_t;
  typedef enum logic [2:0] {
    CCR_ST_IDLE = 3'h1,
    CCR_ST_ISSUE = 3'h2,
    CCR_ST_WAIT = 3'h4
  } ccr_state_t;
endpackage

// *** hdl/ccr_decode_if.sv ***
`timescale 1ns/1ns
interface ccr_decode_if;
  import ccr_pkg::*;
  logic [31:0] cfgAddr;
  logic [7:0]  secBus;
  logic [7:0]  subBus;
  ccr_route_t  route;
  logic        gfxType1;
  logic [4:0]  intDev;
  logic [31:0] linkAddr;
  modport decoder (input cfgAddr, input secBus, input subBus,
                   output route, output gfxType1, output intDev,
                   output linkAddr);
  modport user (output cfgAddr, output secBus, output subBus,
                input route, input gfxType1, input intDev,
                input linkAddr);
endinterface

// *** hdl/ccr_route_decode.sv ***
`timescale 1ns/1ns
`include "ccr_defines.svh"
module ccr_route_decode
  import ccr_pkg::*;
(
  ccr_decode_if.decoder dec
);
  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  wire [7:0] bus  = dec.cfgAddr[`CCR_BUS_MSB:`CCR_BUS_LSB];
  wire [4:0] dev  = dec.cfgAddr[`CCR_DEV_MSB:`CCR_DEV_LSB];
  wire [2:0] func = dec.cfgAddr[`CCR_FUNC_MSB:`CCR_FUNC_LSB];
  wire       enab = dec.cfgAddr[`CCR_CFG_EN_BIT];

  function automatic logic isInternal(input logic [4:0] d);
    isInternal = (d == `CCR_DEV_HUB_BRIDGE) || (d == `CCR_DEV_GFX_BRIDGE)
              || (d == `CCR_DEV_GFX_CTRL) || (d == `CCR_DEV_STREAM_PORT)
              || (d == `CCR_DEV_TEST_REGS) || (d == `CCR_DEV_TEST_ALT);
  endfunction

  // ---------------------------------------------------------------
  // route choice
  // ---------------------------------------------------------------
  wire rootBus  = (bus == `CCR_ROOT_BUS);
  wire intHit   = rootBus && isInternal(dev);
  wire gfxSec   = !rootBus && (bus == dec.secBus);
  wire gfxBelow = !rootBus && (bus > dec.secBus)
                  && (bus <= dec.subBus);

  assign dec.gfxType1 = gfxBelow;
  assign dec.intDev   = dev;
  // function-number filter applies to internal devices only
  assign dec.route = !enab ? CCR_RT_NONE :
                     intHit ? ((func != 3'h0) ? CCR_RT_NONE
                                              : CCR_RT_INT) :
                     (gfxSec || gfxBelow) ? CCR_RT_GFX :
                     CCR_RT_HUB;
  assign dec.linkAddr = {dec.cfgAddr[31:2], `CCR_TYPE1_LOW};
endmodule

// *** hdl/config_cycle_router.sv ***
// How it works
// - bus field 23:16 and device field decoded; bus zero means root bus.
// - root bus device 0 is hub bridge, device 1 graphics bridge.
// - root bus device 6 selects the test register function.
// - nonzero bus outside secondary..subordinate goes to hub link type 1.
// - hub link type 1 packet drives address bits 1:0 as 01.
// - address port bits 31:2 copied into hub packet bits 31:2.
// - graphics bridge primary bus number is fixed at zero.
// - bus equal to secondary bus gives graphics type 0 cycle.
// - type 0 device 0..15 drives one line of 16..31; above 15 none.
// - bus above secondary, up to subordinate, gives graphics type 1.
// - address port at 0cf8, written only by full dword access.
// - byte or word access there passes to hub link as plain I/O.
// - bit 31 enables configuration translation.
// - address port reads and writes, resets to zero.
// - address port holds target of the next data window access.
// - internal device accesses with nonzero function are ignored.
// - root bus with no internal device match goes to hub link.
// - each data window access with bit 31 set starts translation of stored address.
// - type 0 above device 15 selects none; master abort recorded.
`timescale 1ns/1ns
`include "ccr_defines.svh"
module config_cycle_router
  import ccr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ioReq,
  input  wire logic        ioWrite,
  input  wire logic [15:0] ioAddr,
  input  wire logic [3:0]  ioByteEn,
  input  wire logic [31:0] ioWrData,
  output logic             ioDone,
  output logic [31:0]      ioRdData,
  input  wire logic [7:0]  secBusNum,
  input  wire logic [7:0]  subBusNum,
  output logic [7:0]       primaryBusNum,
  output logic             hubLinkReq,
  output logic             hubLinkCfg,
  output logic             hubLinkWrite,
  output logic [31:0]      hubLinkAddr,
  output logic [3:0]       hubLinkByteEn,
  output logic [31:0]      hubLinkWrData,
  input  wire logic        hubLinkDone,
  input  wire logic [31:0] hubLinkRdData,
  output logic             gfxCfgReq,
  output logic             gfxCfgWrite,
  output logic [31:0]      graphicsAddrDataLines,
  output logic [3:0]       gfxByteEn,
  output logic [31:0]      gfxWrData,
  input  wire logic        gfxDone,
  input  wire logic        gfxMasterAbort,
  input  wire logic [31:0] gfxRdData,
  output logic             intCfgReq,
  output logic             intCfgWrite,
  output logic [4:0]       intCfgDev,
  output logic [7:2]       intCfgReg,
  output logic [3:0]       intCfgByteEn,
  output logic [31:0]      intCfgWrData,
  input  wire logic        intCfgDone,
  input  wire logic [31:0] intCfgRdData,
  output logic             gfxMasterAbortSeen
);
  // ---------------------------------------------------------------
  // address port register and decode
  // ---------------------------------------------------------------
  logic [31:0] cfgAddr_ff;
  logic [31:0] nxt_cfgAddr;
  ccr_state_t  state_ff;
  ccr_state_t  nxt_state;
  ccr_route_t  tgt_ff;
  ccr_decode_if decBus ();

  assign decBus.cfgAddr = cfgAddr_ff;
  assign decBus.secBus  = secBusNum;
  assign decBus.subBus  = subBusNum;

  ccr_route_decode uDecode (
    .dec (decBus.decoder)
  );

  wire idle      = (state_ff == CCR_ST_IDLE);
  wire take      = idle && ioReq;
  // dword locations: the low two address bits never take part
  wire [15:0] portIo = `CCR_ADDR_PORT_IO;
  wire [15:0] winIo  = `CCR_DATA_WIN_IO;
  wire hitAddr   = (ioAddr[15:2] == portIo[15:2]);
  wire hitData   = (ioAddr[15:2] == winIo[15:2]);
  wire fullDword = (ioByteEn == `CCR_BE_DWORD);
  wire portHit   = take && hitAddr && fullDword;
  wire cfgCycle  = take && hitData && cfgAddr_ff[`CCR_CFG_EN_BIT];
  wire dropCycle = cfgCycle && (decBus.route == CCR_RT_NONE);
  wire fwdIo     = take && !portHit && !cfgCycle;
  wire [31:0] portRd = {cfgAddr_ff[`CCR_CFG_EN_BIT], 7'h00,
                        cfgAddr_ff[23:2], 2'h0};

  assign nxt_cfgAddr = (portHit && ioWrite) ?
                       {ioWrData[31], 7'h00, ioWrData[23:2], 2'h0}
                       : cfgAddr_ff;

  // ---------------------------------------------------------------
  // graphics address phase
  // ---------------------------------------------------------------
  logic [15:0] idselOneHot;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : gIdsel
      // device 1xxxx never matches, leaving every line low
      assign idselOneHot[gi] =
        (cfgAddr_ff[`CCR_DEV_MSB:`CCR_DEV_LSB] == 5'(gi));
    end
  endgenerate

  wire [31:0] gfxType0Addr = {idselOneHot, 5'h00,
                              cfgAddr_ff[10:2], `CCR_TYPE0_LOW};
  wire [31:0] gfxType1Addr = {8'h00, cfgAddr_ff[23:2],
                              `CCR_TYPE1_LOW};
  wire [31:0] gfxAddr = decBus.gfxType1 ? gfxType1Addr : gfxType0Addr;

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  wire doneIn = (tgt_ff == CCR_RT_HUB) ? hubLinkDone :
                (tgt_ff == CCR_RT_GFX) ? gfxDone :
                (tgt_ff == CCR_RT_INT) ? intCfgDone : 1'b0;
  wire [31:0] rdIn = (tgt_ff == CCR_RT_HUB) ? hubLinkRdData :
                     (tgt_ff == CCR_RT_GFX) ? gfxRdData :
                     intCfgRdData;
  wire startXfer = (cfgCycle && !dropCycle) || fwdIo;
  wire localDone = portHit || dropCycle;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CCR_ST_IDLE:  if (startXfer) nxt_state = CCR_ST_ISSUE;
      CCR_ST_ISSUE: nxt_state = CCR_ST_WAIT;
      CCR_ST_WAIT:  if (doneIn) nxt_state = CCR_ST_IDLE;
      default:      nxt_state = CCR_ST_IDLE;
    endcase
  end

  wire [3:0] nxt_tgtBits = fwdIo ? CCR_RT_HUB : decBus.route;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgAddr_ff <= `CCR_ADDR_PORT_RST;
      state_ff   <= CCR_ST_IDLE;
      tgt_ff     <= CCR_RT_NONE;
    end else begin
      cfgAddr_ff <= nxt_cfgAddr;
      state_ff   <= nxt_state;
      if (take) tgt_ff <= ccr_route_t'(nxt_tgtBits);
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  // request pulses last one cycle; partners answer with done later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ioDone <= 1'b0;
      ioRdData <= 32'h00000000;
      primaryBusNum <= 8'h00;
      hubLinkReq <= 1'b0;
      hubLinkCfg <= 1'b0;
      hubLinkWrite <= 1'b0;
      hubLinkAddr <= 32'h00000000;
      hubLinkByteEn <= 4'h0;
      hubLinkWrData <= 32'h00000000;
      gfxCfgReq <= 1'b0;
      gfxCfgWrite <= 1'b0;
      graphicsAddrDataLines <= 32'h00000000;
      gfxByteEn <= 4'h0;
      gfxWrData <= 32'h00000000;
      intCfgReq <= 1'b0;
      intCfgWrite <= 1'b0;
      intCfgDev <= 5'h00;
      intCfgReg <= 6'h00;
      intCfgByteEn <= 4'h0;
      intCfgWrData <= 32'h00000000;
      gfxMasterAbortSeen <= 1'b0;
    end else begin
      primaryBusNum <= `CCR_PRIMARY_BUS;
      ioDone <= localDone || (state_ff == CCR_ST_WAIT && doneIn);
      if (portHit) ioRdData <= portRd;
      else if (dropCycle) ioRdData <= 32'hffffffff;
      else if (state_ff == CCR_ST_WAIT && doneIn) ioRdData <= rdIn;
      hubLinkReq <= take && ((cfgCycle && decBus.route == CCR_RT_HUB)
                             || fwdIo);
      gfxCfgReq <= cfgCycle && (decBus.route == CCR_RT_GFX);
      intCfgReq <= cfgCycle && (decBus.route == CCR_RT_INT);
      if (take) begin
        hubLinkCfg <= cfgCycle;
        hubLinkWrite <= ioWrite;
        hubLinkAddr <= cfgCycle ? decBus.linkAddr
                                : {16'h0000, ioAddr};
        hubLinkByteEn <= ioByteEn;
        hubLinkWrData <= ioWrData;
        gfxCfgWrite <= ioWrite;
        graphicsAddrDataLines <= gfxAddr;
        gfxByteEn <= ioByteEn;
        gfxWrData <= ioWrData;
        intCfgWrite <= ioWrite;
        intCfgDev <= decBus.intDev;
        intCfgReg <= cfgAddr_ff[`CCR_REG_MSB:`CCR_REG_LSB];
        intCfgByteEn <= ioByteEn;
        intCfgWrData <= ioWrData;
      end
      // abort is sticky; a later access must not hide it
      if (state_ff == CCR_ST_WAIT && tgt_ff == CCR_RT_GFX
          && gfxDone && gfxMasterAbort)
        gfxMasterAbortSeen <= 1'b1;
    end
  end
endmodule

// *** tb/ccr_props.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// routing checker
// ----------------------------------------
module ccr_props (
  input logic        clk,
  input logic        rst_n,
  input logic        ioReq,
  input logic [15:0] ioAddr,
  input logic [3:0]  ioByteEn,
  input logic        ioDone,
  input logic [7:0]  primaryBusNum,
  input logic        hubLinkReq,
  input logic        hubLinkCfg,
  input logic [31:0] hubLinkAddr,
  input logic        gfxCfgReq,
  input logic [31:0] graphicsAddrDataLines,
  input logic        gfxDone,
  input logic        gfxMasterAbort,
  input logic        intCfgReq,
  input logic [4:0]  intCfgDev,
  input logic        gfxMasterAbortSeen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [31:0] gfxLines = graphicsAddrDataLines;
  property p_prim; primaryBusNum == 8'h00; endproperty
  a_prim: assert property (p_prim) else $error("primary bus nonzero");
  property p_hubLow; hubLinkReq && hubLinkCfg |-> hubLinkAddr[1:0] == 2'h1;
  endproperty
  a_hubLow: assert property (p_hubLow) else $error("hub low bits");
  property p_idsel; gfxCfgReq && gfxLines[1:0] == 2'h0
    |-> $onehot0(gfxLines[31:16]) && gfxLines[15:11] == 5'h00; endproperty
  a_idsel: assert property (p_idsel) else $error("idsel not one hot");
  property p_gfx1; gfxCfgReq && gfxLines[1:0] == 2'h1
    |-> gfxLines[31:24] == 8'h00; endproperty
  a_gfx1: assert property (p_gfx1) else $error("type1 upper bits");
  // a dword access to the port never leaves the block
  property p_port; $rose(ioReq) && ioAddr == 16'h0cf8 && ioByteEn == 4'hf
    |=> ioDone && !hubLinkReq; endproperty
  a_port: assert property (p_port) else $error("port access slow");
  property p_pass; $rose(ioReq) && ioAddr == 16'h0cf8 && ioByteEn != 4'hf
    |=> hubLinkReq && !hubLinkCfg; endproperty
  a_pass: assert property (p_pass) else $error("partial not passed");
  property p_win; $rose(ioReq) && ioAddr == 16'h0cfc
    |=> hubLinkReq || gfxCfgReq || intCfgReq || ioDone; endproperty
  a_win: assert property (p_win) else $error("window not started");
  property p_intDev; intCfgReq |-> intCfgDev inside {5'h00, 5'h01, 5'h02,
    5'h03, 5'h06, 5'h07}; endproperty
  a_intDev: assert property (p_intDev) else $error("bad internal dev");
  property p_abort; gfxDone && gfxMasterAbort
    |=> gfxMasterAbortSeen ##1 gfxMasterAbortSeen; endproperty
  a_abort: assert property (p_abort) else $error("abort not kept");
endmodule

bind config_cycle_router ccr_props u_props (
  .clk                   (clk),
  .rst_n                 (rst_n),
  .ioReq                 (ioReq),
  .ioAddr                (ioAddr),
  .ioByteEn              (ioByteEn),
  .ioDone                (ioDone),
  .primaryBusNum         (primaryBusNum),
  .hubLinkReq            (hubLinkReq),
  .hubLinkCfg            (hubLinkCfg),
  .hubLinkAddr           (hubLinkAddr),
  .gfxCfgReq             (gfxCfgReq),
  .graphicsAddrDataLines (graphicsAddrDataLines),
  .gfxDone               (gfxDone),
  .gfxMasterAbort        (gfxMasterAbort),
  .intCfgReq             (intCfgReq),
  .intCfgDev             (intCfgDev),
  .gfxMasterAbortSeen    (gfxMasterAbortSeen)
);

// *** tb/ccr_far_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// hub link, graphics port and internal devices
// ----------------------------------------
module ccr_far_model (
  input  logic        clk,
  input  logic [2:0]  slow,
  input  logic        hubLinkReq,
  input  logic [31:0] hubLinkAddr,
  input  logic        gfxCfgReq,
  input  logic [31:0] graphicsAddrDataLines,
  input  logic        intCfgReq,
  input  logic [4:0]  intCfgDev,
  output logic        hubLinkDone,
  output logic [31:0] hubLinkRdData,
  output logic        gfxDone,
  output logic        gfxMasterAbort,
  output logic [31:0] gfxRdData,
  output logic        intCfgDone,
  output logic [31:0] intCfgRdData
);
  logic [2:0]  who = 3'h0;
  logic [2:0]  dn  = 3'h0;
  logic [2:0]  cnt = 3'h0;
  logic [31:0] val = 32'h0;
  logic        ab  = 1'b0;
  wire  [31:0] gl  = graphicsAddrDataLines;
  // answers echo the request so the bench can tell the routes apart
  always @(posedge clk) begin
    dn <= 3'h0;
    if (hubLinkReq | gfxCfgReq | intCfgReq) begin
      who <= {hubLinkReq, gfxCfgReq, intCfgReq};
      val <= hubLinkReq ? hubLinkAddr : gfxCfgReq ? gl : {27'h0, intCfgDev};
      ab  <= gfxCfgReq & (gl[1:0] == 2'h0) & (gl[31:16] == 16'h0);
      cnt <= slow;
    end else if (who != 3'h0) begin
      if (cnt == 3'h0) begin
        dn  <= who;
        who <= 3'h0;
      end else begin
        cnt <= cnt - 3'h1;
      end
    end
  end
  // no device selected means nobody claims the cycle
  assign {hubLinkDone, gfxDone, intCfgDone} = dn;
  assign gfxMasterAbort = gfxDone & ab;
  // idle data lines show the inverse, never a stale copy
  assign hubLinkRdData  = hubLinkDone ? val : ~val;
  assign gfxRdData      = gfxDone ? val : ~val;
  assign intCfgRdData   = intCfgDone ? val : ~val;
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import ccr_pkg::*;
  logic        clk, rst_n, ioReq, ioWrite, ioDone, hubLinkReq, hubLinkCfg;
  logic        hubLinkWrite, hubLinkDone, gfxCfgReq, gfxCfgWrite, gfxDone;
  logic        gfxMasterAbort, intCfgReq, intCfgWrite, intCfgDone;
  logic        gfxMasterAbortSeen, sw, sc;
  logic [15:0] ioAddr;
  logic [3:0]  ioByteEn, hubLinkByteEn, gfxByteEn, intCfgByteEn, be, sb;
  logic [31:0] ioWrData, ioRdData, hubLinkAddr, hubLinkWrData, sa, rd, sd;
  logic [31:0] hubLinkRdData, graphicsAddrDataLines, gfxWrData, gfxRdData;
  logic [31:0] intCfgWrData, intCfgRdData;
  logic [7:0]  secBusNum, subBusNum, primaryBusNum;
  logic [4:0]  intCfgDev;
  logic [7:2]  intCfgReg, sr;
  logic [2:0]  slow;
  logic [1:0]  rt;
  int          failures = 0;
  int          tests_run = 0;
  localparam int N = 11;
  logic [31:0] tPort [N] = '{32'h80000010, 32'h80000810, 32'h80000910,
    32'h80003010, 32'h80002810, 32'h80014a24, 32'h80060004,
    32'h80021a0c, 32'h80027800, 32'h80028004, 32'h80051a0c};
  logic [1:0]  tRt [N] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h2};
  logic [31:0] tExp [N] = '{32'h0, 32'h1, 32'hffffffff, 32'h6, 32'h80002811,
    32'h80014a25, 32'h80060005, 32'h0008020c, 32'h80000000, 32'h00000004,
    32'h00051a0d};
  config_cycle_router dut (
    .clk(clk), .rst_n(rst_n), .ioReq(ioReq), .ioWrite(ioWrite),
    .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWrData(ioWrData),
    .ioDone(ioDone), .ioRdData(ioRdData), .secBusNum(secBusNum),
    .subBusNum(subBusNum), .primaryBusNum(primaryBusNum),
    .hubLinkReq(hubLinkReq), .hubLinkCfg(hubLinkCfg),
    .hubLinkWrite(hubLinkWrite), .hubLinkAddr(hubLinkAddr),
    .hubLinkByteEn(hubLinkByteEn), .hubLinkWrData(hubLinkWrData),
    .hubLinkDone(hubLinkDone), .hubLinkRdData(hubLinkRdData),
    .gfxCfgReq(gfxCfgReq), .gfxCfgWrite(gfxCfgWrite),
    .graphicsAddrDataLines(graphicsAddrDataLines),
    .gfxByteEn(gfxByteEn), .gfxWrData(gfxWrData), .gfxDone(gfxDone),
    .gfxMasterAbort(gfxMasterAbort), .gfxRdData(gfxRdData),
    .intCfgReq(intCfgReq), .intCfgWrite(intCfgWrite),
    .intCfgDev(intCfgDev), .intCfgReg(intCfgReg),
    .intCfgByteEn(intCfgByteEn), .intCfgWrData(intCfgWrData),
    .intCfgDone(intCfgDone), .intCfgRdData(intCfgRdData),
    .gfxMasterAbortSeen(gfxMasterAbortSeen)
  );
  ccr_far_model far (
    .clk(clk), .slow(slow), .hubLinkReq(hubLinkReq),
    .hubLinkAddr(hubLinkAddr), .gfxCfgReq(gfxCfgReq),
    .graphicsAddrDataLines(graphicsAddrDataLines),
    .intCfgReq(intCfgReq), .intCfgDev(intCfgDev),
    .hubLinkDone(hubLinkDone), .hubLinkRdData(hubLinkRdData),
    .gfxDone(gfxDone), .gfxMasterAbort(gfxMasterAbort),
    .gfxRdData(gfxRdData), .intCfgDone(intCfgDone),
    .intCfgRdData(intCfgRdData)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // downstream monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (hubLinkReq) begin
      {rt, sw, sc, sa} <= {2'h1, hubLinkWrite, hubLinkCfg, hubLinkAddr};
      {sb, sd} <= {hubLinkByteEn, hubLinkWrData};
    end
    if (gfxCfgReq) begin
      {rt, sw, sc} <= {2'h2, gfxCfgWrite, 1'b1};
      {sa, sb, sd} <= {graphicsAddrDataLines, gfxByteEn, gfxWrData};
    end
    if (intCfgReq) begin
      {rt, sw, sc, sa} <= {2'h3, intCfgWrite, 1'b1, 27'h0, intCfgDev};
      {sb, sd, sr} <= {intCfgByteEn, intCfgWrData, intCfgReg};
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // holds the request until ioDone, drops it before the next edge
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [3:0] b, input logic [31:0] d);
    int n;
    @(negedge clk);
    rt = 2'h0;
    {ioReq, ioWrite, ioAddr, ioByteEn, ioWrData} = {1'b1, w, a, b, d};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ioDone !== 1'b1 && n < 40);
    if (n >= 40) chk("ioDone", 32'h1, 32'h0);
    rd = ioRdData;
    ioReq = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    tally_and_finish;
  end
  initial begin
    {rst_n, ioReq, ioWrite, ioAddr, ioByteEn, ioWrData} = '0;
    {secBusNum, subBusNum, slow, rt} = '0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk("reset", 32'h0, rd);
    chk("primary", 32'h0, {24'h0, primaryBusNum});
    chk("abortSeen", 32'h0, {31'h0, gfxMasterAbortSeen});
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk("offRoute", 32'h1, {30'h0, rt});
    chk("offCfg", 32'h0, {31'h0, sc});
    chk("offAddr", 32'h00000cfc, sa);
    io(1'b1, 16'h0cf8, 4'hf, 32'hffffffff);
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk("mask", 32'h80fffffc, rd);
    io(1'b1, 16'h0cf8, 4'h3, 32'h0);
    chk("wordRoute", 32'h1, {30'h0, rt});
    chk("wordCfg", 32'h0, {31'h0, sc});
    chk("wordAddr", 32'h00000cf8, sa);
    chk("wordBe", 32'h3, {28'h0, sb});
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk("kept", 32'h80fffffc, rd);
    $display("test port done");
    for (int i = 0; i < N; i++) begin
      if (i == 5) {secBusNum, subBusNum} = {8'h02, 8'h05};
      slow = (i == 4) ? 3'h5 : 3'h0;
      io(1'b1, 16'h0cf8, 4'hf, tPort[i]);
      be = i[1] ? 4'h3 : 4'hf;
      io(i[0], 16'h0cfc, be, ~tPort[i]);
      if (tRt[i] != 2'h0) chk("be", {28'h0, be}, {28'h0, sb});
      if (tRt[i] != 2'h0 && i[0]) chk("wdata", ~tPort[i], sd);
      if (tRt[i] == 2'h3) chk("reg", {26'h0, tPort[i][7:2]}, {26'h0, sr});
      chk("route", {30'h0, tRt[i]}, {30'h0, rt});
      if (tRt[i] != 2'h0) chk("addr", tExp[i], sa);
      if (tRt[i] != 2'h0) chk("cfg", 32'h1, {31'h0, sc});
      if (tRt[i] != 2'h0) chk("write", {31'h0, i[0]}, {31'h0, sw});
      if (!i[0]) chk("data", tExp[i], rd);
    end
    chk("abortSeen", 32'h1, {31'h0, gfxMasterAbortSeen});
    $display("test route done");
    tally_and_finish;
  end
endmodule
